//--- common/fifo_offset_pkg.sv
// Constants for the flag offset programming and retransmit setup block.
// Assumes one core clock; all pin timing is seen through synchronisers.
package fifo_offset_pkg;

    // ****
    // Widths and depth steps
    // ****
    localparam int unsigned DATA_W      = 36;
    localparam int unsigned OFFSET_W    = 15;
    localparam logic [3:0]  BASE_USED_W = 4'ha;   // Offset bits at smallest depth
    localparam logic [2:0]  DEPTH_MAX   = 3'h5;   // Six depth steps, 0 to 5

    // Bus width selection codes
    localparam logic [1:0]  WIDTH_X36 = 2'h0;
    localparam logic [1:0]  WIDTH_X18 = 2'h1;
    localparam logic [1:0]  WIDTH_X9  = 2'h2;

    // ****
    // Timing counts, in edges of the sampled pin clocks
    // ****
    localparam logic [1:0]  FLAG_DELAY_EDGES = 2'h2;
    localparam logic [1:0]  RT_SETUP_EDGES   = 2'h2;

    // ****
    // Register offsets and reset values
    // ****
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_STATUS  = 8'h04;
    localparam logic [7:0]  REG_OFFSETS = 8'h08;
    localparam logic [31:0] CTRL_RESET  = 32'h00000000;
    localparam logic [14:0] OFFSET_RESET = 15'h0000;

    // Sampled pin bundle layout
    localparam int unsigned PIN_WCLK = 0;
    localparam int unsigned PIN_RCLK = 1;
    localparam int unsigned PIN_LD   = 2;
    localparam int unsigned PIN_SEN  = 3;
    localparam int unsigned PIN_SI   = 4;
    localparam int unsigned PIN_WEN  = 5;
    localparam int unsigned PIN_REN  = 6;
    localparam int unsigned PIN_RT   = 7;
    localparam int unsigned PIN_MRS  = 8;
    localparam int unsigned PIN_PRS  = 9;
    localparam int unsigned PIN_SER  = 10;
    localparam int unsigned PIN_FALL_THROUGH_MODE = 11;
    localparam int unsigned PIN_INW  = 12;
    localparam int unsigned PIN_OUTW = 14;
    localparam int unsigned PIN_DEP  = 16;
    localparam int unsigned PIN_DATA = 19;
    localparam int unsigned PIN_W    = 55;

endpackage

//--- rtl/pin_sync.sv
// Two-stage synchroniser for a bundle of pins, with rising edge pulses.
// Assumes the pins are asynchronous to core_clk.
module pin_sync #(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    // Pins and sampled view
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinSync,
    output logic      [W-1:0] pinRise
);

    // ****
    // Synchroniser stages
    // ****
    logic [W-1:0] meta_q;
    logic [W-1:0] prev_q;

    // First stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta_q  <= '0;
            pinSync <= '0;
        end else begin
            meta_q  <= pinIn;
            pinSync <= meta_q;
        end
    end

    // Edge detect on the stable stage
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prev_q  <= '0;
            pinRise <= '0;
        end else begin
            prev_q  <= pinSync;
            pinRise <= pinSync & ~prev_q;
        end
    end

endmodule

//--- rtl/flag_valid_delay.sv
// Validity tracker for one programmable flag.
// Assumes edgeEn is a one-cycle pulse per sampled edge of the flag's clock.
module flag_valid_delay (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // Control
    input  wire logic restore,
    input  wire logic invalidate,
    input  wire logic start,
    input  wire logic edgeEn,
    // Status
    output logic      valid
);

    logic [1:0] cnt_q;

    // Start arms a count of edges; valid rises on the last one
    always_ff @(posedge core_clk) begin
        if (sys_rst || restore) begin
            cnt_q <= 2'h0;
            valid <= 1'b1;
        end else if (start) begin
            cnt_q <= fifo_offset_pkg::FLAG_DELAY_EDGES;
            valid <= 1'b0;
        end else if (invalidate) begin
            cnt_q <= 2'h0;
            valid <= 1'b0;
        end else if (edgeEn && cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
            valid <= (cnt_q == 2'h1);
        end
    end

endmodule

//--- rtl/fifo_flag_offset_and_retransmit.sv
// Flag offset registers, their serial and parallel loading and readback,
// and retransmit setup of the read pointer.
// Assumes all FIFO pins are asynchronous and are sampled on core_clk.
//
// Operation
// - one serial bit per write edge
// - serial load is twice used width
// - serial load covers both offsets
// - load low, shift enable high: no write
// - serial load pauses, resumes next bit
// - flags valid two edges after completion
// - offsets read only on data output; the register port also returns both at REG_OFFSETS
// - x36 writes alternate empty, full
// - x18 writes four parts then wrap
// - x9 takes six parallel write cycles
// - separate write and read offset pointers
// - master reset clears pointers, partial keeps
// - parallel load pauses, resumes in order
// - x36 reads alternate empty, full
// - x18 or x9 reads four or six
// - readback resumes where stopped
// - offset read overwrites output word
// - readback works in both timing modes
// - retransmit low rewinds read pointer
// - standard mode: empty low at setup
// - empty high marks setup complete
// - fall-through ready marks setup, word appears
//
// Our own choices: the address-and-strobe port and the placing of the registers.
module fifo_flag_offset_and_retransmit (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Write side pins
    input  wire logic        writeClkPin,
    input  wire logic        offsetLoadSelectN,
    input  wire logic        serialShiftEnableN,
    input  wire logic        serialIn,
    input  wire logic        writeEnableN,
    input  wire logic [35:0] writeDataBus,
    // Read side pins
    input  wire logic        readClkPin,
    input  wire logic        readEnableN,
    input  wire logic        retransmitN,
    // Resets and straps
    input  wire logic        masterResetN,
    input  wire logic        partialResetN,
    input  wire logic        serialProgMode,
    input  wire logic        fallThroughMode,
    input  wire logic [1:0]  inWidthSel,
    input  wire logic [1:0]  outWidthSel,
    input  wire logic [2:0]  depthSel,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [31:0] regRdData,
    // Outputs
    output logic      [35:0] readDataBus,
    output logic             emptyFlagN,
    output logic             outputReadyN,
    output logic             almostFullValid,
    output logic             almostEmptyValid,
    output logic      [14:0] memReadPtr
);

    // ****
    // Pin sampling
    // ****
    logic [fifo_offset_pkg::PIN_W-1:0] pinsRaw;
    logic [fifo_offset_pkg::PIN_W-1:0] pins;
    logic [fifo_offset_pkg::PIN_W-1:0] pinsRise;

    assign pinsRaw = {writeDataBus, depthSel, outWidthSel, inWidthSel, fallThroughMode,
                      serialProgMode, partialResetN, masterResetN, retransmitN,
                      readEnableN, writeEnableN, serialIn, serialShiftEnableN,
                      offsetLoadSelectN, readClkPin, writeClkPin};

    pin_sync #(
        .W (fifo_offset_pkg::PIN_W)
    ) u_pins (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pinIn    (pinsRaw),
        .pinSync  (pins),
        .pinRise  (pinsRise)
    );

    logic        wEdge;
    logic        rEdge;
    logic        ldN;
    logic        senN;
    logic        wenN;
    logic        renN;
    logic        rtN;
    logic        mrsActive;
    logic        prsActive;
    logic [35:0] dataIn;

    assign wEdge     = pinsRise[fifo_offset_pkg::PIN_WCLK];
    assign rEdge     = pinsRise[fifo_offset_pkg::PIN_RCLK];
    assign ldN       = pins[fifo_offset_pkg::PIN_LD];
    assign senN      = pins[fifo_offset_pkg::PIN_SEN];
    assign wenN      = pins[fifo_offset_pkg::PIN_WEN];
    assign renN      = pins[fifo_offset_pkg::PIN_REN];
    assign rtN       = pins[fifo_offset_pkg::PIN_RT];
    assign mrsActive = ~pins[fifo_offset_pkg::PIN_MRS];
    assign prsActive = ~pins[fifo_offset_pkg::PIN_PRS];
    assign dataIn    = pins[fifo_offset_pkg::PIN_DATA +: 36];

    // ****
    // Configuration captured during master reset
    // ****
    logic       cfgSerial_q;
    logic       cfgFwft_q;
    logic [1:0] cfgInW_q;
    logic [1:0] cfgOutW_q;
    logic [2:0] cfgDepth_q;

    // Straps follow pins during master reset
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cfgSerial_q <= 1'b0;
            cfgFwft_q   <= 1'b0;
            cfgInW_q    <= fifo_offset_pkg::WIDTH_X36;
            cfgOutW_q   <= fifo_offset_pkg::WIDTH_X36;
            cfgDepth_q  <= 3'h0;
        end else if (mrsActive) begin
            cfgSerial_q <= pins[fifo_offset_pkg::PIN_SER];
            cfgFwft_q   <= pins[fifo_offset_pkg::PIN_FALL_THROUGH_MODE];
            cfgInW_q    <= pins[fifo_offset_pkg::PIN_INW +: 2];
            cfgOutW_q   <= pins[fifo_offset_pkg::PIN_OUTW +: 2];
            cfgDepth_q  <= (pins[fifo_offset_pkg::PIN_DEP +: 3] > fifo_offset_pkg::DEPTH_MAX)
                           ? fifo_offset_pkg::DEPTH_MAX : pins[fifo_offset_pkg::PIN_DEP +: 3];
        end
    end

    // ****
    // Part geometry helpers
    // ****
    function automatic logic [5:0] laneWidth(input logic [1:0] w);
        unique case (w)
            fifo_offset_pkg::WIDTH_X18: laneWidth = 6'd18;
            fifo_offset_pkg::WIDTH_X9:  laneWidth = 6'd9;
            default:                    laneWidth = 6'd36;
        endcase
    endfunction

    function automatic logic [2:0] partsPer(input logic [1:0] w);
        unique case (w)
            fifo_offset_pkg::WIDTH_X18: partsPer = 3'h2;
            fifo_offset_pkg::WIDTH_X9:  partsPer = 3'h3;
            default:                    partsPer = 3'h1;
        endcase
    endfunction

    // Merge one lane into an offset
    function automatic logic [14:0] mergePart(input logic [14:0] old, input logic [35:0] d,
                                              input logic [5:0] sh, input logic [5:0] lw,
                                              input logic [3:0] uw);
        logic [35:0] m;
        logic [35:0] wide;
        m    = ({36{1'b1}} >> (6'd36 - lw)) << sh;
        wide = {21'h0, old};
        wide = (wide & ~m) | ((d << sh) & m);
        mergePart = wide[14:0] & (15'h7fff >> (4'hf - uw));
    endfunction

    logic [3:0] usedW;
    logic [4:0] serialTotal;
    logic [2:0] inParts;
    logic [2:0] outParts;

    assign usedW       = fifo_offset_pkg::BASE_USED_W + {1'b0, cfgDepth_q};
    assign serialTotal = {usedW, 1'b0};
    assign inParts     = partsPer(cfgInW_q);
    assign outParts    = partsPer(cfgOutW_q);

    // ****
    // Offset loading
    // ****
    logic [14:0] emptyOffset_q;
    logic [14:0] fullOffset_q;
    logic [4:0]  serialCnt_q;
    logic [2:0]  wrPtr_q;
    logic        serialShift;
    logic        parWrite;
    logic        serialToFull;
    logic [3:0]  serialBit;
    logic        wrToFull;
    logic [2:0]  wrPart;
    logic [5:0]  wrShift;

    assign serialShift  = wEdge & ~ldN & ~senN & cfgSerial_q;
    assign parWrite     = wEdge & ~ldN & ~wenN & ~cfgSerial_q;
    assign serialToFull = (serialCnt_q >= {1'b0, usedW});
    assign serialBit    = serialToFull ? 4'(serialCnt_q - {1'b0, usedW}) : serialCnt_q[3:0];
    assign wrToFull     = (wrPtr_q >= inParts);
    assign wrPart       = wrToFull ? 3'(wrPtr_q - inParts) : wrPtr_q;
    assign wrShift      = 6'(wrPart * laneWidth(cfgInW_q));

    // Offset contents survive partial reset
    always_ff @(posedge core_clk) begin
        if (sys_rst || mrsActive) begin
            emptyOffset_q <= fifo_offset_pkg::OFFSET_RESET;
            fullOffset_q  <= fifo_offset_pkg::OFFSET_RESET;
        end else if (serialShift) begin
            if (serialToFull) begin
                fullOffset_q[serialBit] <= pins[fifo_offset_pkg::PIN_SI];
            end else begin
                emptyOffset_q[serialBit] <= pins[fifo_offset_pkg::PIN_SI];
            end
        end else if (parWrite) begin
            if (wrToFull) begin
                fullOffset_q <= mergePart(fullOffset_q, dataIn, wrShift,
                                          laneWidth(cfgInW_q), usedW);
            end else begin
                emptyOffset_q <= mergePart(emptyOffset_q, dataIn, wrShift,
                                           laneWidth(cfgInW_q), usedW);
            end
        end
    end

    // Serial bit count wraps after whole set
    always_ff @(posedge core_clk) begin
        if (sys_rst || mrsActive) begin
            serialCnt_q <= 5'h0;
        end else if (serialShift) begin
            serialCnt_q <= (serialCnt_q == serialTotal - 5'h1) ? 5'h0
                                                              : serialCnt_q + 5'h1;
        end
    end

    // Parallel write pointer, independent of the read pointer
    always_ff @(posedge core_clk) begin
        if (sys_rst || mrsActive) begin
            wrPtr_q <= 3'h0;
        end else if (parWrite) begin
            wrPtr_q <= (wrPtr_q == {inParts[1:0], 1'b0} - 3'h1) ? 3'h0
                                                                : wrPtr_q + 3'h1;
        end
    end

    // ****
    // Flag validity
    // ****
    logic serialFirst;
    logic serialLast;
    logic aeInvalidate;
    logic afInvalidate;
    logic aeStart;
    logic afStart;

    assign serialFirst  = serialShift & (serialCnt_q == 5'h0);
    assign serialLast   = serialShift & (serialCnt_q == serialTotal - 5'h1);
    assign aeInvalidate = serialFirst | (parWrite & ~wrToFull & (wrPart == 3'h0));
    assign afInvalidate = serialFirst | (parWrite & wrToFull & (wrPart == 3'h0));
    assign aeStart      = serialLast | (parWrite & ~wrToFull & (wrPart == inParts - 3'h1));
    assign afStart      = serialLast | (parWrite & wrToFull & (wrPart == inParts - 3'h1));

    // Almost-full counts write edges after completion
    flag_valid_delay u_afValid (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .restore    (mrsActive | prsActive),
        .invalidate (afInvalidate),
        .start      (afStart),
        .edgeEn     (wEdge),
        .valid      (almostFullValid)
    );

    // Almost-empty counts read edges after completion
    flag_valid_delay u_aeValid (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .restore    (mrsActive | prsActive),
        .invalidate (aeInvalidate),
        .start      (aeStart),
        .edgeEn     (rEdge),
        .valid      (almostEmptyValid)
    );

    // ****
    // Offset readback
    // ****
    logic [2:0]  rdPtr_q;
    logic        offRead;
    logic        rdToFull;
    logic [2:0]  rdPart;
    logic [5:0]  rdShift;
    logic [35:0] rdMask;
    logic [35:0] rdWord;

    assign offRead  = rEdge & ~ldN & ~renN;
    assign rdToFull = (rdPtr_q >= outParts);
    assign rdPart   = rdToFull ? 3'(rdPtr_q - outParts) : rdPtr_q;
    assign rdShift  = 6'(rdPart * laneWidth(cfgOutW_q));
    assign rdMask   = {36{1'b1}} >> (6'd36 - laneWidth(cfgOutW_q));
    assign rdWord   = ({21'h0, rdToFull ? fullOffset_q : emptyOffset_q} >> rdShift) & rdMask;

    // Read pointer advances only on offset reads
    always_ff @(posedge core_clk) begin
        if (sys_rst || mrsActive) begin
            rdPtr_q <= 3'h0;
        end else if (offRead) begin
            rdPtr_q <= (rdPtr_q == {outParts[1:0], 1'b0} - 3'h1) ? 3'h0
                                                                 : rdPtr_q + 3'h1;
        end
    end

    // Output register, cleared by either reset
    always_ff @(posedge core_clk) begin
        if (sys_rst || mrsActive || prsActive) begin
            readDataBus <= 36'h000000000;
        end else if (offRead) begin
            readDataBus <= rdWord;
        end
    end

    // ****
    // Retransmit setup
    // ****
    logic [31:0] ctrl_q;
    logic [1:0]  rtCnt_q;
    logic        zeroLatency;
    logic        rtStart;
    logic        setupBusy;

    assign zeroLatency = ctrl_q[0];
    assign setupBusy   = (rtCnt_q != 2'h0);
    assign rtStart     = rEdge & ~rtN & ~setupBusy;

    // Setup length; zero latency ends at once
    always_ff @(posedge core_clk) begin
        if (sys_rst || mrsActive || prsActive) begin
            rtCnt_q <= 2'h0;
        end else if (rtStart) begin
            rtCnt_q <= zeroLatency ? 2'h0 : fifo_offset_pkg::RT_SETUP_EDGES;
        end else if (rEdge && setupBusy) begin
            rtCnt_q <= rtCnt_q - 2'h1;
        end
    end

    // Memory read pointer rewound by retransmit
    always_ff @(posedge core_clk) begin
        if (sys_rst || mrsActive || prsActive) begin
            memReadPtr <= 15'h0000;
        end else if (rtStart) begin
            memReadPtr <= zeroLatency ? 15'h0001 : 15'h0000;
        end else if (rEdge && rtCnt_q == 2'h1 && cfgFwft_q) begin
            memReadPtr <= 15'h0001;
        end else if (rEdge && ldN && !renN && !setupBusy) begin
            memReadPtr <= memReadPtr + 15'h0001;
        end
    end

    // Status pins mark the start and end of setup
    always_ff @(posedge core_clk) begin
        if (sys_rst || mrsActive || prsActive) begin
            emptyFlagN   <= 1'b0;
            outputReadyN <= 1'b1;
        end else if (rtStart && !zeroLatency) begin
            emptyFlagN   <= cfgFwft_q;
            outputReadyN <= 1'b1;
        end else if ((rtStart && zeroLatency) || (rEdge && rtCnt_q == 2'h1)) begin
            emptyFlagN   <= 1'b1;
            outputReadyN <= ~cfgFwft_q;
        end
    end

    // ****
    // Register port
    // ****
    // Control register: bit 0 selects zero latency retransmit
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_q <= fifo_offset_pkg::CTRL_RESET;
        end else if (regWrite && regAddr == fifo_offset_pkg::REG_CTRL) begin
            ctrl_q <= {31'h0, regWrData[0]};
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst || !regRead) begin
            regRdData <= 32'h00000000;
        end else begin
            unique case (regAddr)
                fifo_offset_pkg::REG_CTRL:    regRdData <= ctrl_q;
                fifo_offset_pkg::REG_STATUS:  regRdData <= {13'h0, cfgFwft_q, cfgSerial_q,
                                                            cfgDepth_q, almostEmptyValid,
                                                            almostFullValid, setupBusy,
                                                            serialCnt_q, rdPtr_q, wrPtr_q};
                fifo_offset_pkg::REG_OFFSETS: regRdData <= {1'b0, fullOffset_q,
                                                            1'b0, emptyOffset_q};
                default:                      regRdData <= 32'h00000000;
            endcase
        end
    end

endmodule

//--- test/fifo_offset_chk.sv
// Port checks for the offset and retransmit block.
// Assumes pins are held steady across each pin clock pulse.
module fifo_offset_chk (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        sys_rst,
    // Pins
    input wire logic        offsetLoadSelectN,
    input wire logic        retransmitN,
    input wire logic        masterResetN,
    input wire logic        partialResetN,
    // Outputs
    input wire logic [35:0] readDataBus,
    input wire logic        emptyFlagN,
    input wire logic        almostFullValid,
    input wire logic [14:0] memReadPtr
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Properties
    // ****
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    a_mrs_clears_out:
        assert property (!masterResetN [*6] |-> readDataBus == 36'h0 && memReadPtr == 15'h0)
        else $error("master reset left outputs set");
    a_prs_clears_ptr:
        assert property (!partialResetN [*6] |-> memReadPtr == 15'h0 && !emptyFlagN)
        else $error("partial reset left pointer set");
    a_bus_hold_away:
        assert property ((offsetLoadSelectN && masterResetN && partialResetN) [*6]
            |-> $stable(readDataBus)) else $error("bus moved without read");
    a_af_drop_load:
        assert property ($fell(almostFullValid) |-> !$past(offsetLoadSelectN, 4))
        else $error("flag dropped, no load");
    a_af_stays_low:
        assert property ($fell(almostFullValid) |-> !almostFullValid [*8])
        else $error("flag valid too soon");
    a_ef_fall_rt:
        assert property ($fell(emptyFlagN) && partialResetN && masterResetN
            |-> !$past(retransmitN, 4)) else $error("empty fell without retransmit");
    a_rt_ptr_zero:
        assert property ($fell(emptyFlagN) |-> memReadPtr == 15'h0)
        else $error("pointer not rewound");
    a_setup_bounded:
        assert property ($fell(emptyFlagN) && partialResetN && masterResetN |-> ##[1:60] emptyFlagN)
        else $error("setup did not complete");
    c_rt_setup: cover property ($fell(emptyFlagN));
    c_af_valid: cover property ($rose(almostFullValid));
    c_readback: cover property ($changed(readDataBus));
endmodule
bind fifo_flag_offset_and_retransmit fifo_offset_chk chk_u (.core_clk, .sys_rst,
    .offsetLoadSelectN, .retransmitN, .masterResetN, .partialResetN, .readDataBus,
    .emptyFlagN, .almostFullValid, .memReadPtr);

//--- test/host_pin_model.sv
// Host pin model: one-cycle requests become pin clock pulses.
// Assumes requests arrive at least ten core cycles apart.
module host_pin_model (
    // Clock and requests
    input  wire logic core_clk,
    input  wire logic wGo,
    input  wire logic rGo,
    // Pin clocks, idle low between pulses
    output logic      writeClkPin = 1'b0,
    output logic      readClkPin = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd;
    // One pulse per request
    always @(posedge core_clk) begin
        if (wGo || rGo) begin
            rd = rGo;
            repeat (4) @(posedge core_clk);
            {readClkPin, writeClkPin} <= {rd, !rd};
            repeat (3) @(posedge core_clk);
            {readClkPin, writeClkPin} <= 2'h0;
        end
    end
endmodule

//--- test/tb_top.sv
// Bench for offset loading, readback and retransmit setup.
// Assumes the host pin model paces the pin clocks.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Signals
    // ****
    logic        core_clk = 1'b0, sys_rst = 1'b1, wGo = 1'b0, rGo = 1'b0, serialIn = 1'b0;
    logic        offsetLoadSelectN = 1'b1, serialShiftEnableN = 1'b1, writeEnableN = 1'b1;
    logic        readEnableN = 1'b1, retransmitN = 1'b1, masterResetN = 1'b0;
    logic        partialResetN = 1'b1, serialProgMode = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic [1:0]  outWidthSel = 2'h0;
    logic [2:0]  depthSel = 3'h0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, regRdData, e, f, s;
    logic [35:0] writeDataBus = 36'h0, readDataBus, expQ[$];
    logic [14:0] memReadPtr;
    logic        writeClkPin, readClkPin, emptyFlagN, outputReadyN;
    logic        almostFullValid, almostEmptyValid;
    int          err_total = 0, comparisons = 0, seed = 41935;
    host_pin_model host_u (.core_clk, .wGo, .rGo, .writeClkPin, .readClkPin);
    fifo_flag_offset_and_retransmit dut_u (.core_clk, .sys_rst, .writeClkPin,
        .offsetLoadSelectN, .serialShiftEnableN, .serialIn, .writeEnableN, .writeDataBus,
        .readClkPin, .readEnableN, .retransmitN, .masterResetN, .partialResetN,
        .serialProgMode, .fallThroughMode(1'b0), .inWidthSel(2'h0), .outWidthSel, .depthSel,
        .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .readDataBus, .emptyFlagN,
        .outputReadyN, .almostFullValid, .almostEmptyValid, .memReadPtr);
    task automatic check(input string n, input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One pin clock pulse at a time, never read and write together
    task automatic pulse(input bit rd);
        wGo <= !rd;
        rGo <= rd;
        @(posedge core_clk);
        wGo <= 1'b0;
        rGo <= 1'b0;
        repeat (10) @(posedge core_clk);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 check("regRdData", 36'(regRdData), 36'(exp));
    endtask
    task automatic mres(input logic ser, input logic [1:0] ow, input logic [2:0] dep);
        masterResetN <= 1'b0;
        serialProgMode <= ser;
        outWidthSel <= ow;
        depthSel <= dep;
        repeat (8) @(posedge core_clk);
        masterResetN <= 1'b1;
        repeat (6) @(posedge core_clk);
    endtask
    // Scoreboard: oldest note per offset read
    always @(posedge readClkPin) begin
        if (!offsetLoadSelectN && !readEnableN) begin
            repeat (6) @(posedge core_clk);
            #1 check("readDataBus", readDataBus, expQ.pop_front());
        end
    end
    // Clock and watchdog
    initial forever #4 core_clk = ~core_clk;
    initial begin
        #100000;
        err_total++;
        wrap_up();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        mres(1'b0, fifo_offset_pkg::WIDTH_X36, 3'h2);
        e = $random(seed);
        f = $random(seed);
        offsetLoadSelectN <= 1'b0;
        writeEnableN <= 1'b0;
        writeDataBus <= {4'hf, e};
        pulse(0);
        writeEnableN <= 1'b1;
        pulse(0);
        offsetLoadSelectN <= 1'b1;
        writeEnableN <= 1'b0;
        writeDataBus <= {4'hf, f};
        pulse(0);
        offsetLoadSelectN <= 1'b0;
        pulse(0);
        writeEnableN <= 1'b1;
        rreg(fifo_offset_pkg::REG_OFFSETS, {4'h0, f[11:0], 4'h0, e[11:0]});
        expQ = '{36'(e[11:0]), 36'(f[11:0]), 36'(e[11:0])};
        readEnableN <= 1'b0;
        pulse(1);
        readEnableN <= 1'b1;
        pulse(1);
        readEnableN <= 1'b0;
        repeat (2) pulse(1);
        readEnableN <= 1'b1;
        $display("test parallel done");
        mres(1'b1, fifo_offset_pkg::WIDTH_X18, 3'h0);
        s = $random(seed);
        for (int i = 0; i < 21; i++) begin
            serialShiftEnableN <= (i == 7);
            serialIn <= (i == 7) ? ~s[7] : s[i - (i > 7)];
            pulse(0);
        end
        #1 check("afValid", 36'(almostFullValid), 36'h0);
        offsetLoadSelectN <= 1'b1;
        repeat (2) pulse(0);
        #1 check("afValid", 36'(almostFullValid), 36'h1);
        e = {6'h0, s[19:10], 6'h0, s[9:0]};
        rreg(fifo_offset_pkg::REG_OFFSETS, e);
        expQ = '{36'(s[9:0]), 36'h0, 36'(s[19:10]), 36'h0};
        offsetLoadSelectN <= 1'b0;
        readEnableN <= 1'b0;
        repeat (4) pulse(1);
        readEnableN <= 1'b1;
        offsetLoadSelectN <= 1'b1;
        #1 check("aeValid", 36'(almostEmptyValid), 36'h1);
        partialResetN <= 1'b0;
        repeat (8) @(posedge core_clk);
        partialResetN <= 1'b1;
        repeat (6) @(posedge core_clk);
        rreg(fifo_offset_pkg::REG_OFFSETS, e);
        $display("test serial done");
        readEnableN <= 1'b0;
        repeat (2) pulse(1);
        readEnableN <= 1'b1;
        #1 check("memReadPtr", 36'(memReadPtr), 36'h2);
        for (int k = 0; k < 2; k++) begin
            retransmitN <= 1'b0;
            pulse(1);
            retransmitN <= 1'b1;
            repeat (2) pulse(1);
            #1 check("emptyFlagN", 36'(emptyFlagN), 36'h1);
            check("memReadPtr", 36'(memReadPtr), 36'h0);
            check("outputReadyN", 36'(outputReadyN), 36'h1);
        end
        regAddr <= fifo_offset_pkg::REG_CTRL;
        regWrData <= 32'h00000001;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        rreg(fifo_offset_pkg::REG_CTRL, 32'h00000001);
        rreg(8'h0c, 32'h00000000);
        retransmitN <= 1'b0;
        pulse(1);
        #1 check("memReadPtr", 36'(memReadPtr), 36'h1);
        $display("test retransmit done");
        wrap_up();
    end
endmodule
